// [logic/chan_cfg_reg.v]
`timescale 1ns/1ns
`include "drv_cfg_consts.vh"
// one channel control register with optional writable top bit
module chan_cfg_reg #(
  parameter HAS_TOP = 0
) (
  input wire sysClk,
  input wire arstN,
  input wire wrEn,
  input wire [7:0] wrData,
  output reg topBit,
  output reg [1:0] fmtSel,
  output reg [1:0] modeA,
  output reg [1:0] modeB,
  output wire [7:0] rdValue
);
  // fields load on own write only
  always @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      topBit <= (HAS_TOP != 0) ? `CH0_TOP_RST : 1'b0;
      fmtSel <= `SEL_RST;
      modeA <= `MODEA_RST;
      modeB <= `MODEB_RST;
    end else if (wrEn) begin
      if (HAS_TOP != 0) begin
        topBit <= wrData[`RSV_TOP_BIT];
      end
      fmtSel <= wrData[`SEL_HI:`SEL_LO];
      modeA <= wrData[`MODEA_HI:`MODEA_LO];
      modeB <= wrData[`MODEB_HI:`MODEB_LO];
    end
  end
  // bit 0 reads zero
  assign rdValue = {topBit, fmtSel, modeA, modeB, 1'b0};
endmodule

// [logic/drv_cfg_consts.vh]
`ifndef DRV_CFG_CONSTS_VH
`define DRV_CFG_CONSTS_VH
// register addresses
`define ADDR_W 8
`define ADDR_OUT0_CTL 8'h1f
`define ADDR_OUT1_CTL 8'h20
// field positions
`define RSV_TOP_BIT 7
`define SEL_HI 6
`define SEL_LO 5
`define MODEA_HI 4
`define MODEA_LO 3
`define MODEB_HI 2
`define MODEB_LO 1
// reset values
`define SEL_RST 2'h1
`define MODEA_RST 2'h2
`define MODEB_RST 2'h0
`define CH0_TOP_RST 1'h1
`define DRVON_RST 2'h3
// driver formats
`define FMT_OFF 2'h0
`define FMT_ACDIFF 2'h1
`define FMT_HCSL 2'h2
`define FMT_CMOS 2'h3
// pin mode codes
`define PIN_TRI 2'h0
`define PIN_LOW 2'h1
`define PIN_INV 2'h2
`define PIN_TRUE 2'h3
// tail current codes, milliamps
`define TAIL_4MA 5'h04
`define TAIL_6MA 5'h06
`define TAIL_8MA 5'h08
`define TAIL_16MA 5'h10
`endif

// [logic/drv_decode.v]
`timescale 1ns/1ns
`include "drv_cfg_consts.vh"
// decodes one channel's fields into driver controls
module drv_decode (
  input wire [1:0] fmtSel,
  input wire [1:0] modeA,
  input wire [1:0] modeB,
  input wire peclSel,
  output reg drvOn,
  output reg hcslOn,
  output reg cmosOn,
  output reg [4:0] tailMa,
  output reg [1:0] loadSel,
  output reg pPowered,
  output reg pDriveLow,
  output reg pInvert,
  output reg nPowered,
  output reg nDriveLow,
  output reg nInvert
);
  always @* begin
    drvOn = (fmtSel != `FMT_OFF);
    hcslOn = (fmtSel == `FMT_HCSL);
    cmosOn = (fmtSel == `FMT_CMOS);
    tailMa = `TAIL_4MA;
    loadSel = `PIN_TRI;
    pPowered = 1'b0;
    pDriveLow = 1'b0;
    pInvert = 1'b0;
    nPowered = 1'b0;
    nDriveLow = 1'b0;
    nInvert = 1'b0;
    if (fmtSel == `FMT_ACDIFF || fmtSel == `FMT_HCSL) begin
      // tail current, code 3 capped for pecl
      case (modeA)
        2'h0: tailMa = `TAIL_4MA;
        2'h1: tailMa = `TAIL_6MA;
        2'h2: tailMa = `TAIL_8MA;
        default: tailMa = peclSel ? `TAIL_8MA : `TAIL_16MA;
      endcase
      loadSel = modeB;
    end else if (cmosOn) begin
      pPowered = modeA[1];
      pDriveLow = (modeA == `PIN_LOW);
      pInvert = (modeA == `PIN_INV);
      nPowered = modeB[1];
      nDriveLow = (modeB == `PIN_LOW);
      nInvert = (modeB == `PIN_INV);
    end
  end
endmodule

// [logic/output_driver_config_regs.v]
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "drv_cfg_consts.vh"
module output_driver_config_regs (
  input wire sysClk,
  input wire arst_n,
  input wire [7:0] regAddr,
  input wire [7:0] wrData,
  input wire wrStb,
  input wire rdStb,
  input wire ch0Pecl,
  input wire ch1Pecl,
  output reg [7:0] rdData,
  output reg [1:0] ch0Format,
  output reg [1:0] ch0_drive_mode_a,
  output reg [1:0] ch0_drive_mode_b,
  output reg ch0Reserved,
  output reg [1:0] ch1Format,
  output reg [1:0] ch1_drive_mode_a,
  output reg [1:0] ch1_drive_mode_b,
  output reg [1:0] drvOn,
  output reg [1:0] hcslOn,
  output reg [1:0] cmosOn,
  output reg [9:0] tailMa,
  output reg [3:0] hcslLoad,
  output reg [1:0] pPowered,
  output reg [1:0] pDriveLow,
  output reg [1:0] pInvert,
  output reg [1:0] nPowered,
  output reg [1:0] nDriveLow,
  output reg [1:0] nInvert
);
  wire wr0;
  wire wr1;
  wire top0;
  wire [1:0] sel0;
  wire [1:0] sel1;
  wire [1:0] ma0;
  wire [1:0] ma1;
  wire [1:0] mb0;
  wire [1:0] mb1;
  wire [7:0] rv0;
  wire [7:0] rv1;
  wire pecl0;
  wire pecl1;
  reg ch0PeclMeta;
  reg ch0PeclSync;
  reg ch1PeclMeta;
  reg ch1PeclSync;
  wire [1:0] dOn;
  wire [1:0] dHcsl;
  wire [1:0] dCmos;
  wire [4:0] dTail0;
  wire [4:0] dTail1;
  wire [1:0] dLoad0;
  wire [1:0] dLoad1;
  wire [1:0] dPp;
  wire [1:0] dPl;
  wire [1:0] dPi;
  wire [1:0] dNp;
  wire [1:0] dNl;
  wire [1:0] dNi;
  reg [7:0] next_rdData;

  // address decode
  assign wr0 = wrStb && (regAddr == `ADDR_OUT0_CTL);
  assign wr1 = wrStb && (regAddr == `ADDR_OUT1_CTL);

  // channel 0 keeps its writable top bit, channel 1 does not
  chan_cfg_reg #(
    .HAS_TOP(1)
  ) reg0 (
    .sysClk(sysClk),
    .arstN(arst_n),
    .wrEn(wr0),
    .wrData(wrData),
    .topBit(top0),
    .fmtSel(sel0),
    .modeA(ma0),
    .modeB(mb0),
    .rdValue(rv0)
  );

  chan_cfg_reg #(
    .HAS_TOP(0)
  ) reg1 (
    .sysClk(sysClk),
    .arstN(arst_n),
    .wrEn(wr1),
    .wrData(wrData),
    .topBit(),
    .fmtSel(sel1),
    .modeA(ma1),
    .modeB(mb1),
    .rdValue(rv1)
  );

  // pecl straps come from pins, two-stage sync
  always @(posedge sysClk or negedge arst_n) begin
    if (!arst_n) begin
      ch0PeclMeta <= 1'b0;
      ch0PeclSync <= 1'b0;
      ch1PeclMeta <= 1'b0;
      ch1PeclSync <= 1'b0;
    end else begin
      ch0PeclMeta <= ch0Pecl;
      ch0PeclSync <= ch0PeclMeta;
      ch1PeclMeta <= ch1Pecl;
      ch1PeclSync <= ch1PeclMeta;
    end
  end
  assign pecl0 = ch0PeclSync;
  assign pecl1 = ch1PeclSync;

  // per-channel decoders
  drv_decode dec0 (
    .fmtSel(sel0),
    .modeA(ma0),
    .modeB(mb0),
    .peclSel(pecl0),
    .drvOn(dOn[0]),
    .hcslOn(dHcsl[0]),
    .cmosOn(dCmos[0]),
    .tailMa(dTail0),
    .loadSel(dLoad0),
    .pPowered(dPp[0]),
    .pDriveLow(dPl[0]),
    .pInvert(dPi[0]),
    .nPowered(dNp[0]),
    .nDriveLow(dNl[0]),
    .nInvert(dNi[0])
  );

  drv_decode dec1 (
    .fmtSel(sel1),
    .modeA(ma1),
    .modeB(mb1),
    .peclSel(pecl1),
    .drvOn(dOn[1]),
    .hcslOn(dHcsl[1]),
    .cmosOn(dCmos[1]),
    .tailMa(dTail1),
    .loadSel(dLoad1),
    .pPowered(dPp[1]),
    .pDriveLow(dPl[1]),
    .pInvert(dPi[1]),
    .nPowered(dNp[1]),
    .nDriveLow(dNl[1]),
    .nInvert(dNi[1])
  );

  // read mux, unmapped reads zero
  always @* begin
    next_rdData = rdData;
    if (rdStb) begin
      case (regAddr)
        `ADDR_OUT0_CTL: next_rdData = rv0;
        `ADDR_OUT1_CTL: next_rdData = rv1;
        default: next_rdData = 8'h00;
      endcase
    end
  end

  // registered outputs
  always @(posedge sysClk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= 8'h00;
      ch0Format <= `SEL_RST;
      ch0_drive_mode_a <= `MODEA_RST;
      ch0_drive_mode_b <= `MODEB_RST;
      ch0Reserved <= `CH0_TOP_RST;
      ch1Format <= `SEL_RST;
      ch1_drive_mode_a <= `MODEA_RST;
      ch1_drive_mode_b <= `MODEB_RST;
      drvOn <= `DRVON_RST;
      hcslOn <= 2'h0;
      cmosOn <= 2'h0;
      tailMa <= {`TAIL_8MA, `TAIL_8MA};
      hcslLoad <= 4'h0;
      pPowered <= 2'h0;
      pDriveLow <= 2'h0;
      pInvert <= 2'h0;
      nPowered <= 2'h0;
      nDriveLow <= 2'h0;
      nInvert <= 2'h0;
    end else begin
      rdData <= next_rdData;
      ch0Format <= sel0;
      ch0_drive_mode_a <= ma0;
      ch0_drive_mode_b <= mb0;
      ch0Reserved <= top0;
      ch1Format <= sel1;
      ch1_drive_mode_a <= ma1;
      ch1_drive_mode_b <= mb1;
      drvOn <= dOn;
      hcslOn <= dHcsl;
      cmosOn <= dCmos;
      tailMa <= {dTail1, dTail0};
      hcslLoad <= {dLoad1, dLoad0};
      pPowered <= dPp;
      pDriveLow <= dPl;
      pInvert <= dPi;
      nPowered <= dNp;
      nDriveLow <= dNl;
      nInvert <= dNi;
    end
  end
endmodule

// [tb/drv_cfg_monitor.sv]
`timescale 1ns/1ns
module drv_cfg_monitor (
  input wire sysClk,
  input wire arst_n,
  input wire [7:0] regAddr,
  input wire [7:0] wrData,
  input wire wrStb,
  input wire rdStb,
  input wire [7:0] rdData,
  input wire [1:0] ch0Format,
  input wire [1:0] ch0_drive_mode_a,
  input wire [1:0] ch1Format,
  input wire [1:0] ch1_drive_mode_a,
  input wire [1:0] ch1_drive_mode_b,
  input wire [1:0] cmosOn,
  input wire [9:0] tailMa,
  input wire [3:0] hcslLoad
);
  // every check runs on the register clock
  default clocking @(posedge sysClk);
  endclocking
  default disable iff (!arst_n);
  // field capture and channel isolation on writes
  chk_fmt_capture: assert property (wrStb && regAddr == 8'h1f |-> ##2
    ch0Format == $past(wrData[6:5], 2))
    else $error("format not captured");
  chk_modea_capture: assert property (wrStb && regAddr == 8'h20 |-> ##2
    ch1_drive_mode_a == $past(wrData[4:3], 2))
    else $error("mode a not captured");
  chk_chan_indep: assert property (wrStb && regAddr == 8'h20 |-> ##2 $stable({ch0Format, ch0_drive_mode_a}))
    else $error("channel 0 moved on channel 1 write");
  // decoded outputs and field copies load on the same edge
  chk_cmos_on: assert property (cmosOn[1] == (ch1Format == 2'h3))
    else $error("cmos enable wrong");
  chk_tail_low: assert property (ch0Format inside {2'h1, 2'h2} && ch0_drive_mode_a != 2'h3 |->
    tailMa[4:0] == 5'h04 + {2'h0, ch0_drive_mode_a, 1'b0})
    else $error("tail current wrong");
  chk_load_sel: assert property (ch1Format == 2'h2 |-> hcslLoad[3:2] == ch1_drive_mode_b)
    else $error("load select wrong");
  // read port
  chk_rd_ch1: assert property (rdStb && regAddr == 8'h20 |=>
    rdData == {1'b0, ch1Format, ch1_drive_mode_a, ch1_drive_mode_b, 1'b0})
    else $error("channel 1 readback wrong");
  chk_rd_unmap: assert property (rdStb && regAddr != 8'h1f && regAddr != 8'h20 |=> rdData == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind output_driver_config_regs drv_cfg_monitor mon_u (.sysClk(sysClk), .arst_n(arst_n), .regAddr(regAddr),
  .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .ch0Format(ch0Format),
  .ch0_drive_mode_a(ch0_drive_mode_a), .ch1Format(ch1Format), .ch1_drive_mode_a(ch1_drive_mode_a),
  .ch1_drive_mode_b(ch1_drive_mode_b), .cmosOn(cmosOn), .tailMa(tailMa), .hcslLoad(hcslLoad));

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  reg sysClk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [7:0] wrData = 8'h00;
  reg wrStb = 1'b0;
  reg rdStb = 1'b0;
  reg [1:0] pecl = 2'h0;
  wire [7:0] rdData;
  wire [9:0] tailMa;
  wire [3:0] hcslLoad;
  wire [1:0] pPowered;
  wire [1:0] pInvert;
  wire [1:0] nDriveLow;
  wire [1:0] ch0ModeB;
  wire ch0Reserved;
  wire [1:0] drvOn;
  wire [1:0] hcslOn;
  wire [1:0] cmosOn;
  wire [1:0] pDriveLow;
  wire [1:0] nPowered;
  wire [1:0] nInvert;
  int failures = 0;
  int comparisons = 0;
  // 20 MHz clock
  always #25 sysClk = ~sysClk;
  output_driver_config_regs dut_u (.sysClk(sysClk), .arst_n(arst_n), .regAddr(regAddr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .ch0Pecl(pecl[0]), .ch1Pecl(pecl[1]), .rdData(rdData), .ch0Format(),
    .ch0_drive_mode_a(), .ch0_drive_mode_b(ch0ModeB), .ch0Reserved(ch0Reserved), .ch1Format(),
    .ch1_drive_mode_a(), .ch1_drive_mode_b(), .drvOn(drvOn), .hcslOn(hcslOn), .cmosOn(cmosOn),
    .tailMa(tailMa), .hcslLoad(hcslLoad), .pPowered(pPowered), .pDriveLow(pDriveLow), .pInvert(pInvert),
    .nPowered(nPowered), .nDriveLow(nDriveLow), .nInvert(nInvert));
  // compare and count
  task chk(input logic [9:0] seen, input logic [9:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regAddr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge sysClk);
    wrStb <= 1'b0;
  endtask
  // write, then wait until decoded outputs have settled
  task wr_settle(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (2) @(posedge sysClk);
    #1;
  endtask
  // one-cycle read strobe, data checked in the following cycle
  task rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge sysClk);
    regAddr <= a;
    rdStb <= 1'b1;
    @(posedge sysClk);
    rdStb <= 1'b0;
    #1 chk({2'h0, rdData}, {2'h0, want});
  endtask
  task t_reset;
    rd(8'h1f, 8'hb0);
    rd(8'h20, 8'h30);
    chk(tailMa, 10'h108);
    chk({1'b0, ch0Reserved, ch0ModeB, drvOn, hcslOn, cmosOn}, 10'h130);
    chk({4'h0, pPowered, pDriveLow, pInvert}, 10'h000);
    chk({4'h0, nPowered, nDriveLow, nInvert}, 10'h000);
    $display("reset values done");
  endtask
  // every format code, reserved bits, unmapped place
  task t_fields;
    for (int f = 0; f < 4; f++) begin
      wr(8'h20, {1'b1, f[1:0], 5'h1f});
      rd(8'h20, {1'b0, f[1:0], 5'h1e});
    end
    rd(8'h1f, 8'hb0);
    wr(8'h1f, 8'h01);
    rd(8'h1f, 8'h00);
    rd(8'h20, 8'h7e);
    rd(8'h21, 8'h00);
    $display("fields done");
  endtask
  // decoded hcsl and cmos controls
  task t_decode;
    wr(8'h20, 8'h5e);
    repeat (2) @(posedge sysClk);
    #1 chk({tailMa[9:5], 3'h0, hcslLoad[3:2]}, 10'h203);
    @(posedge sysClk);
    pecl <= 2'h2;
    repeat (5) @(posedge sysClk);
    #1 chk({5'h00, tailMa[9:5]}, 10'h008);
    wr(8'h1f, 8'h72);
    repeat (2) @(posedge sysClk);
    #1 chk({2'h0, tailMa[4:0], pPowered[0], pInvert[0], nDriveLow[0]}, 10'h027);
    $display("decode done");
  endtask
  // channel 0 tail codes, cmos pin codes, format off, unmapped writes
  task t_codes;
    wr_settle(8'h1f, 8'h20);
    chk({tailMa[4:0], 1'b0, hcslLoad[1:0], drvOn[0], hcslOn[0]}, 10'h082);
    wr_settle(8'h1f, 8'h2a);
    chk({tailMa[4:0], 1'b0, hcslLoad[1:0], drvOn[0], hcslOn[0]}, 10'h0c6);
    wr_settle(8'h1f, 8'h3c);
    chk({tailMa[4:0], 1'b0, hcslLoad[1:0], drvOn[0], hcslOn[0]}, 10'h20a);
    @(posedge sysClk);
    pecl <= 2'h3;
    repeat (5) @(posedge sysClk);
    #1 chk({tailMa[4:0], 1'b0, hcslLoad[1:0], drvOn[0], hcslOn[0]}, 10'h10a);
    wr_settle(8'h1f, 8'h78);
    chk({cmosOn[0], drvOn[0], hcslOn[0], 1'b0, pPowered[0], pDriveLow[0], pInvert[0], nPowered[0], nDriveLow[0],
      nInvert[0]}, 10'h320);
    wr_settle(8'h1f, 8'h6c);
    chk({cmosOn[0], drvOn[0], hcslOn[0], 1'b0, pPowered[0], pDriveLow[0], pInvert[0], nPowered[0], nDriveLow[0],
      nInvert[0]}, 10'h315);
    wr_settle(8'h1f, 8'h1e);
    chk({tailMa[4:0], 1'b0, hcslLoad[1:0], drvOn[0], hcslOn[0]}, 10'h080);
    chk({cmosOn[0], drvOn[0], hcslOn[0], 1'b0, pPowered[0], pDriveLow[0], pInvert[0], nPowered[0], nDriveLow[0],
      nInvert[0]}, 10'h000);
    chk({7'h00, ch0Reserved, ch0ModeB}, 10'h003);
    chk({tailMa[9:5], 3'h0, hcslLoad[3:2]}, 10'h103);
    wr(8'h21, 8'hff);
    wr(8'h1e, 8'hff);
    rd(8'h1f, 8'h1e);
    rd(8'h20, 8'h5e);
    $display("codes done");
  endtask
  // reset in mid run restores every field
  task t_midrst;
    @(posedge sysClk);
    arst_n <= 1'b0;
    #1 chk({rdData, drvOn}, 10'h003);
    chk(tailMa, 10'h108);
    repeat (3) @(posedge sysClk);
    arst_n <= 1'b1;
    t_reset;
    $display("mid-run reset done");
  endtask
  task end_sim;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sysClk);
    arst_n <= 1'b1;
    t_reset;
    t_fields;
    t_decode;
    t_codes;
    t_midrst;
    end_sim;
  end
  // hang guard
  initial begin
    #200000;
    failures++;
    end_sim;
  end
endmodule
